// ### logic/pcfg_map.svh
`ifndef PCFG_MAP_SVH
`define PCFG_MAP_SVH

// Register indices; byte address is four times the index
`define PCFG_IDX_P0_MODE 8'h8F
`define PCFG_IDX_P1_DIR 8'hFE
`define PCFG_IDX_P2_DIR 8'hFF
`define PCFG_IDX_P0_PULL 8'h90

// Reset values
`define PCFG_RST_P0_MODE 8'h00
`define PCFG_RST_P1_DIR 8'h00
`define PCFG_RST_P2_DIR 5'h00
`define PCFG_RST_PRIO 2'h0
`define PCFG_RST_PULL 1'h0

// Field positions in port2_direction_and_priority
`define PCFG_P2_DIR_MSB 4
`define PCFG_P2_UNUSED_BIT 5
`define PCFG_PRIO_LSB 6
`define PCFG_PRIO_MSB 7

// Field position in the pull polarity register
`define PCFG_PULL_BIT 0

// Bus answer latency in cycles after a request appears
`define PCFG_ACK_CYCLES 1

`endif

// ### logic/pcfg_pkg.sv
package pcfg_pkg;

  typedef enum logic [1:0] {
    PCFG_PRIO_U0_U1 = 2'h0,
    PCFG_PRIO_U1_U0 = 2'h1,
    PCFG_PRIO_T1CH01_U1 = 2'h2,
    PCFG_PRIO_T1CH2_U0 = 2'h3
  } pcfg_prio_t;

  typedef enum logic [1:0] {
    PCFG_BUS_IDLE = 2'h0,
    PCFG_BUS_RESP = 2'h1
  } pcfg_bus_state_t;

  typedef enum logic [2:0] {
    PCFG_REG_NONE = 3'h0,
    PCFG_REG_P0_MODE = 3'h1,
    PCFG_REG_P1_DIR = 3'h2,
    PCFG_REG_P2_DIR = 3'h3,
    PCFG_REG_P0_PULL = 3'h4
  } pcfg_reg_t;

endpackage

// ### logic/pcfg_prio.sv
`timescale 1ns/1ps
module pcfg_prio
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Priority code about to be stored
  input pcfg_pkg::pcfg_prio_t next_prio_i,
  // One-hot winner flags
  output logic u0_over_u1_o,
  output logic u1_over_u0_o,
  output logic t1ch01_over_u1_o,
  output logic t1ch2_over_u0_o
);
  import pcfg_pkg::*;

  logic [3:0] grant;
  logic [3:0] next_grant;

  always_comb
  begin
    next_grant = grant;
    if (ce_i)
    begin
      case (next_prio_i)
        PCFG_PRIO_U0_U1: next_grant = 4'h1;
        PCFG_PRIO_U1_U0: next_grant = 4'h2;
        PCFG_PRIO_T1CH01_U1: next_grant = 4'h4;
        PCFG_PRIO_T1CH2_U0: next_grant = 4'h8;
        default: next_grant = 4'h1;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      grant <= 4'h1;
    else
      grant <= next_grant;
  end

  assign u0_over_u1_o = grant[0];
  assign u1_over_u0_o = grant[1];
  assign t1ch01_over_u1_o = grant[2];
  assign t1ch2_over_u0_o = grant[3];

endmodule // pcfg_prio

// ### logic/pcfg_top.sv
`timescale 1ns/1ps
`include "pcfg_map.svh"
module pcfg_top
(
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Classic Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Pin direction, 1 drives the pin
  output logic [7:0] port1_direction_o,
  output logic [4:0] port2_direction_o,
  // Port-0 input conditioning
  output logic [7:0] port0_input_mode_o,
  output logic [7:0] port0_pull_up_en_o,
  output logic [7:0] port0_pull_down_en_o,
  // Port-0 peripheral priority
  output pcfg_pkg::pcfg_prio_t port0_peripheral_priority_o,
  output logic prio_u0_over_u1_o,
  output logic prio_u1_over_u0_o,
  output logic prio_t1ch01_over_u1_o,
  output logic prio_t1ch2_over_u0_o
);
  import pcfg_pkg::*;

  // Register index to register, shared by read and write paths
  function automatic pcfg_reg_t decode_idx(input logic [7:0] idx);
    pcfg_reg_t r;
    r = PCFG_REG_NONE;
    case (idx)
      `PCFG_IDX_P0_MODE: r = PCFG_REG_P0_MODE;
      `PCFG_IDX_P1_DIR: r = PCFG_REG_P1_DIR;
      `PCFG_IDX_P2_DIR: r = PCFG_REG_P2_DIR;
      `PCFG_IDX_P0_PULL: r = PCFG_REG_P0_PULL;
      default: r = PCFG_REG_NONE;
    endcase
    return r;
  endfunction

  // Pull enables for pins left in pull mode
  function automatic logic [7:0] pull_en(
    input logic [7:0] mode,
    input logic polarity,
    input logic want_down
  );
    logic [7:0] en;
    en = 8'h00;
    if (polarity == want_down)
      en = ~mode;
    return en;
  endfunction

  // Configuration state
  logic [7:0] p0_mode;
  logic [7:0] p1_dir;
  logic [4:0] p2_dir;
  pcfg_prio_t prio;
  logic pull_pol;
  logic [7:0] next_p0_mode;
  logic [7:0] next_p1_dir;
  logic [4:0] next_p2_dir;
  pcfg_prio_t next_prio;
  logic next_pull_pol;

  // Bus state
  pcfg_bus_state_t bus_state;
  pcfg_bus_state_t next_bus_state;
  logic [31:0] next_dat;
  logic next_ack;
  logic next_err;

  // Next values of the registered pin-side pull enables
  logic [7:0] next_pu;
  logic [7:0] next_pd;

  pcfg_reg_t hit;
  logic req;
  logic commit;

  assign hit = decode_idx(wb_adr_i[9:2]);
  assign req = wb_cyc_i && wb_stb_i;
  // Only the low byte lane carries register data
  assign commit = (bus_state == PCFG_BUS_RESP) && req && wb_we_i &&
                  wb_sel_i[0] && wb_ack_o;

  // Bus handshake: answer one cycle after the request appears
  always_comb
  begin
    next_bus_state = bus_state;
    next_ack = wb_ack_o;
    next_err = wb_err_o;
    next_dat = wb_dat_o;
    if (ce_i)
    begin
      case (bus_state)
        PCFG_BUS_IDLE:
        begin
          next_ack = 1'b0;
          next_err = 1'b0;
          if (req)
          begin
            next_bus_state = PCFG_BUS_RESP;
            next_ack = (hit != PCFG_REG_NONE);
            next_err = (hit == PCFG_REG_NONE);
            next_dat = 32'h0000_0000;
            case (hit)
              PCFG_REG_P0_MODE: next_dat[7:0] = p0_mode;
              PCFG_REG_P1_DIR: next_dat[7:0] = p1_dir;
              PCFG_REG_P2_DIR:
                next_dat[7:0] = {prio, 1'b0, p2_dir};
              PCFG_REG_P0_PULL: next_dat[`PCFG_PULL_BIT] = pull_pol;
              default: next_dat = 32'h0000_0000;
            endcase
          end
        end
        PCFG_BUS_RESP:
        begin
          // Answer stands one cycle, then rest for one
          next_bus_state = PCFG_BUS_IDLE;
          next_ack = 1'b0;
          next_err = 1'b0;
        end
        default:
        begin
          next_bus_state = PCFG_BUS_IDLE;
          next_ack = 1'b0;
          next_err = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_state <= PCFG_BUS_IDLE;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      bus_state <= next_bus_state;
      wb_ack_o <= next_ack;
      wb_err_o <= next_err;
      wb_dat_o <= next_dat;
    end
  end

  // Register writes take effect at the edge that ends the ack cycle
  always_comb
  begin
    next_p0_mode = p0_mode;
    next_p1_dir = p1_dir;
    next_p2_dir = p2_dir;
    next_prio = prio;
    next_pull_pol = pull_pol;
    if (ce_i && commit)
    begin
      case (hit)
        PCFG_REG_P0_MODE: next_p0_mode = wb_dat_i[7:0];
        PCFG_REG_P1_DIR: next_p1_dir = wb_dat_i[7:0];
        PCFG_REG_P2_DIR:
        begin
          // Bit 5 has no storage, so it cannot be set
          next_p2_dir = wb_dat_i[`PCFG_P2_DIR_MSB:0];
          next_prio = pcfg_prio_t'(
            wb_dat_i[`PCFG_PRIO_MSB:`PCFG_PRIO_LSB]);
        end
        PCFG_REG_P0_PULL:
          next_pull_pol = wb_dat_i[`PCFG_PULL_BIT];
        default:
        begin
          next_p0_mode = p0_mode;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      p0_mode <= `PCFG_RST_P0_MODE;
      p1_dir <= `PCFG_RST_P1_DIR;
      p2_dir <= `PCFG_RST_P2_DIR;
      prio <= pcfg_prio_t'(`PCFG_RST_PRIO);
      pull_pol <= `PCFG_RST_PULL;
    end
    else
    begin
      p0_mode <= next_p0_mode;
      p1_dir <= next_p1_dir;
      p2_dir <= next_p2_dir;
      prio <= next_prio;
      pull_pol <= next_pull_pol;
    end
  end

  // Pin-side outputs follow the same edge as the stored register
  always_comb
  begin
    next_pu = pull_en(next_p0_mode, next_pull_pol, 1'b0);
    next_pd = pull_en(next_p0_mode, next_pull_pol, 1'b1);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port1_direction_o <= `PCFG_RST_P1_DIR;
      port2_direction_o <= `PCFG_RST_P2_DIR;
      port0_input_mode_o <= `PCFG_RST_P0_MODE;
      port0_pull_up_en_o <= 8'hFF;
      port0_pull_down_en_o <= 8'h00;
      port0_peripheral_priority_o <= pcfg_prio_t'(`PCFG_RST_PRIO);
    end
    else
    begin
      // Mirrors the stored fields, visible from the next cycle
      port1_direction_o <= next_p1_dir;
      port2_direction_o <= next_p2_dir;
      port0_input_mode_o <= next_p0_mode;
      port0_pull_up_en_o <= next_pu;
      port0_pull_down_en_o <= next_pd;
      port0_peripheral_priority_o <= next_prio;
    end
  end

  pcfg_prio u_prio
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .next_prio_i(next_prio),
    .u0_over_u1_o(prio_u0_over_u1_o),
    .u1_over_u0_o(prio_u1_over_u0_o),
    .t1ch01_over_u1_o(prio_t1ch01_over_u1_o),
    .t1ch2_over_u0_o(prio_t1ch2_over_u0_o)
  );

endmodule // pcfg_top

// ### verif/pcfg_checker.sv
`timescale 1ns/1ps
module pcfg_checker
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // Pins and priority
  input wire logic [7:0] port1_direction_o,
  input wire logic [4:0] port2_direction_o,
  input wire logic [7:0] port0_input_mode_o,
  input wire logic [7:0] port0_pull_up_en_o,
  input wire logic [7:0] port0_pull_down_en_o,
  input wire pcfg_pkg::pcfg_prio_t port0_peripheral_priority_o,
  input wire logic prio_u0_over_u1_o,
  input wire logic prio_u1_over_u0_o,
  input wire logic prio_t1ch01_over_u1_o,
  input wire logic prio_t1ch2_over_u0_o
);
  import pcfg_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wr_hit;
  assign wr_hit = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_latency: assert property (
    wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o && !wb_err_o
    |=> wb_ack_o || wb_err_o)
    else $error("bus answer late");
  a_p1_write: assert property (
    wr_hit && wb_adr_i[9:2] == 8'hFE
    |=> port1_direction_o == $past(wb_dat_i[7:0]))
    else $error("port1 direction not written");
  a_p1_hold: assert property (
    !(wr_hit && wb_adr_i[9:2] == 8'hFE) |=> $stable(port1_direction_o))
    else $error("port1 direction changed unasked");
  a_p2_write: assert property (
    wr_hit && wb_adr_i[9:2] == 8'hFF
    |=> port2_direction_o == $past(wb_dat_i[4:0]) &&
    port0_peripheral_priority_o == $past(wb_dat_i[7:6]))
    else $error("port2 register not written");
  a_bit5_zero: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i[9:2] == 8'hFF |-> wb_dat_o[5] == 1'b0)
    else $error("unused bit reads one");
  a_mode_write: assert property (
    wr_hit && wb_adr_i[9:2] == 8'h8F
    |=> port0_input_mode_o == $past(wb_dat_i[7:0]))
    else $error("input mode not written");
  a_prio_decode: assert property (
    {prio_u0_over_u1_o, prio_u1_over_u0_o,
    prio_t1ch01_over_u1_o, prio_t1ch2_over_u0_o} ==
    4'h8 >> port0_peripheral_priority_o)
    else $error("priority decode wrong");
  a_pull_cover: assert property (
    (port0_pull_up_en_o | port0_pull_down_en_o) == ~port0_input_mode_o &&
    (port0_pull_up_en_o & port0_pull_down_en_o) == 8'h00)
    else $error("pull enables wrong");
endmodule // pcfg_checker
bind pcfg_top pcfg_checker i_chk (.*);

// ### verif/pcfg_pin_model.sv
`timescale 1ns/1ps
module pcfg_pin_model
(
  // Clock
  input wire logic clk_i,
  // Pad controls
  input wire logic [7:0] mode_i,
  input wire logic [7:0] pull_up_i,
  input wire logic [7:0] pull_down_i,
  // Resolved port-0 levels
  output logic [7:0] pin_o
);
  logic [7:0] ext = 8'h5A;
  // Undriven pads wander so a stale value never passes
  always_ff @(posedge clk_i)
    ext <= ~ext;
  // Pads with neither pull follow the wandering outside level
  assign pin_o = (ext & ~(pull_up_i | pull_down_i)) |
                 (pull_up_i & ~mode_i);
endmodule // pcfg_pin_model

// ### verif/tb_pcfg_top.sv
`timescale 1ns/1ps
module tb_pcfg_top;
  import pcfg_pkg::*;
  logic clk_i = 0, rst_i = 1, ce_i = 1, cyc = 0, stb = 0, we = 0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'hF;
  logic [3:0] lane = 4'hF;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, err, e;
  logic [7:0] p1, mode, pu, pd, pin0;
  logic [4:0] p2;
  logic [3:0] win;
  pcfg_prio_t prio;
  int err_count = 0, cmp_count = 0;
  pcfg_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .port1_direction_o(p1), .port2_direction_o(p2),
    .port0_input_mode_o(mode), .port0_pull_up_en_o(pu),
    .port0_pull_down_en_o(pd), .port0_peripheral_priority_o(prio),
    .prio_u0_over_u1_o(win[3]), .prio_u1_over_u0_o(win[2]),
    .prio_t1ch01_over_u1_o(win[1]), .prio_t1ch2_over_u0_o(win[0]));
  pcfg_pin_model i_pins (.clk_i(clk_i), .mode_i(mode), .pull_up_i(pu),
    .pull_down_i(pd), .pin_o(pin0));
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] idx,
    input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= lane;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (!(ack === 1'b1 || err === 1'b1) && n < 50);
    q = rdat;
    e = err;
    if (ack !== 1'b1 && err !== 1'b1)
    begin
      err_count++;
      $display("[ERR] %0t no bus answer", $time);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] x);
    xfer(1'b0, idx, 8'h00);
    chk(q, {24'h000000, x});
  endtask
  task automatic t_reset;
    rd(8'h8F, 8'h00);
    rd(8'hFE, 8'h00);
    rd(8'hFF, 8'h00);
    chk({pu, pd}, 16'hFF00);
    chk({mode, p1, p2, prio}, 32'h0);
    chk(win, 4'h8);
    $display("reset values done");
  endtask
  task automatic t_dir;
    xfer(1'b1, 8'hFE, 8'hA5);
    chk(p1, 8'hA5);
    rd(8'hFE, 8'hA5);
    xfer(1'b1, 8'hFF, 8'hFF);
    chk(p2, 5'h1F);
    rd(8'hFF, 8'hDF);
    $display("direction done");
  endtask
  task automatic t_prio;
    for (int k = 0; k < 4; k++)
    begin
      xfer(1'b1, 8'hFF, {k[1:0], 6'h15});
      chk(prio, k[1:0]);
      chk(win, 4'h8 >> k);
      chk(p2, 5'h15);
    end
    $display("priority done");
  endtask
  task automatic t_pull;
    xfer(1'b1, 8'h8F, 8'h0F);
    chk(mode, 8'h0F);
    chk(pin0[7:4], 4'hF);
    xfer(1'b1, 8'h90, 8'h01);
    chk({pu, pd}, 16'h00F0);
    chk(pin0[7:4], 4'h0);
    $display("pull done");
  endtask
  task automatic t_bad;
    xfer(1'b1, 8'h10, 8'hFF);
    chk(e, 1'b1);
    chk(q, 32'h0);
    // Write with the low byte lane off is answered but not stored
    lane = 4'hE;
    xfer(1'b1, 8'hFE, 8'h3C);
    chk(e, 1'b0);
    lane = 4'hF;
    rd(8'hFE, 8'hA5);
    $display("unmapped done");
  endtask
  task automatic t_ce;
    @(posedge clk_i);
    ce_i <= 1'b0;
    fork
      xfer(1'b1, 8'hFE, 8'h5A);
      begin
        repeat (4) @(posedge clk_i);
        chk({ack, err, p1}, {2'b00, 8'hA5});
        ce_i <= 1'b1;
      end
    join
    chk(p1, 8'h5A);
    $display("clock enable done");
  endtask
  task automatic t_rst2;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    $display("second reset done");
  endtask
  initial
  begin
    #50000;
    err_count++;
    end_sim;
  end
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_dir;
    t_prio;
    t_pull;
    t_bad;
    t_ce;
    t_rst2;
    end_sim;
  end
endmodule // tb_pcfg_top
